// File: src/erc_pkg.sv
// Behaviour
// - periodic reset ignores breaks, trace, concurrent access
// - no-break and timeout modes ignore software breakpoints
// - sequential mode uses only user channels one, two
// - stop address halts before execution, single run
// - armed stop address disables user channel two
// - identifier qualifies stop address against page entry
// - report fetch address at each monitor interval
// - concurrent access stalls target during memory access
// - run timer with three resolutions and overflow
// - record termination cause on every stop
// - zero break opcode stops as illegal instruction
// - guarded or protected access stops the run
// - user error forces target reset, recorded
// - timeout mode stops on perf timeout, count
// - report status only when it changes
// - report reset while target reset low
// - bus idle 1.28 ms reports timeout, address
// - wait low reports wait, address unless refresh
// - bus request low reports bus request
// - distinct sleep and standby status codes
// - periodic reset pulses at twelve intervals
// - sequential stop needs channel two then one
package erc_pkg;
  localparam int CLK_NS = 25;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STOP = 8'h04;
  localparam logic [7:0] OFF_ASID = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_CAUSE_LO = 8'h10;
  localparam logic [7:0] OFF_CAUSE_HI = 8'h14;
  localparam logic [7:0] OFF_RTIME = 8'h18;
  localparam logic [7:0] OFF_REP = 8'h1C;
  localparam logic [7:0] OFF_MON = 8'h20;
  localparam logic [7:0] OFF_CMD = 8'h24;
  localparam int PSEL_LSB = 4;
  localparam int TRES_LSB = 8;
  localparam int ASID_EN_BIT = 8;
  localparam int CMD_GO = 0;
  localparam int CMD_ABORT = 1;
  localparam int CMD_CONC_ON = 2;
  localparam int CMD_CONC_OFF = 3;
  localparam logic [31:0] MON_RST = 32'h00009C40;
  localparam int CAUSE_W = 39;
  localparam int CS_A = 0;
  localparam int CS_B = 8;
  localparam int CS_C = 16;
  localparam int CS_UBC = 24;
  localparam int CS_SEQ = 27;
  localparam int CS_KEY = 28;
  localparam int CS_BP = 29;
  localparam int CS_BSEQ = 30;
  localparam int CS_STOP = 31;
  localparam int CS_MULTI = 32;
  localparam int CS_TOVF = 33;
  localparam int CS_ILL = 34;
  localparam int CS_GUARD = 35;
  localparam int CS_EMURST = 36;
  localparam int CS_SUBTO = 37;
  localparam int CS_SUBCNT = 38;
  localparam int BUS_TO_NS = 1280000;
  localparam int BUS_TO_CYC = (BUS_TO_NS + CLK_NS - 1) / CLK_NS;
  localparam int PRST_W_CYC = 4;
  localparam int RES_NS [3] = '{1600, 406, 20};
  localparam longint HR_NS = 64'h00000346_30B8A000;
  localparam longint RT_MAX [3] = '{488 * HR_NS / 1600,
    124 * HR_NS / 406, 6 * HR_NS / 20};
  typedef int unsigned erc_tab_t [12];
  localparam erc_tab_t PRST_NS = '{6500, 9800, 50000, 100000, 500000,
    1000000, 5000000, 10000000, 50000000, 100000000, 500000000,
    1000000000};
  function automatic erc_tab_t erc_cyc_tab();
    erc_tab_t t;
    for (int i = 0; i < 12; i++)
      t[i] = (PRST_NS[i] / CLK_NS > 0) ? PRST_NS[i] / CLK_NS : 1;
    return t;
  endfunction
  localparam erc_tab_t PRST_CYC_DEF = erc_cyc_tab();
  typedef enum logic [2:0] {MD_NORMAL, MD_PERIODIC_RST, MD_NO_BREAK,
    MD_SEQ_BREAK, MD_TIMEOUT_BREAK} erc_mode_t;
  typedef enum logic [3:0] {ST_NONE, ST_PC, ST_RESET, ST_RUNNING,
    ST_SLEEP, ST_STANDBY, ST_BUS_TIMEOUT, ST_WAIT,
    ST_BUS_REQUEST} erc_stat_t;
  typedef struct packed {
    logic [31:0] pc_fetch;
    logic fetch_valid;
    logic [31:0] addr;
    logic bus_cycle;
    logic refresh;
    logic wait_n;
    logic bus_request_line_n;
    logic target_reset_line_n;
    logic sleep;
    logic standby;
    logic brk_opcode;
    logic guard_viol;
    logic user_err;
    logic [7:0] page_entry_high_reg;
  } erc_tgt_t;
  typedef struct packed {
    logic [7:0] ch_a;
    logic [7:0] ch_b;
    logic [7:0] ch_c;
    logic [2:0] user_break_channel;
    logic sw_bp;
    logic bp_seq;
    logic trace_ovf;
    logic perf_timeout_counter;
    logic perf_count_ovf;
    logic mem_access;
  } erc_brk_t;
  typedef struct packed {
    logic valid;
    erc_stat_t code;
    logic [31:0] addr;
  } erc_rep_t;
endpackage

// File: src/erc_run_timer.sv
`timescale 1ns/1ps
module erc_run_timer (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic clear,
  input wire logic run,
  input wire logic [1:0] res,
  // result
  output logic [30:0] count,
  output logic ovf
);
  import erc_pkg::*;
  typedef struct packed {
    logic [30:0] cnt;
    logic [11:0] acc;
    logic ovf;
  } erc_tm_t;
  erc_tm_t tm_reg, tm_next;
  logic [11:0] sum, rns;
  logic [30:0] lim;
  always_comb
  begin
    tm_next = tm_reg;
    rns = 12'(RES_NS[0]);
    lim = 31'(RT_MAX[0]);
    if (res == 2'h1)
    begin
      rns = 12'(RES_NS[1]);
      lim = 31'(RT_MAX[1]);
    end
    else if (res == 2'h2)
    begin
      rns = 12'(RES_NS[2]);
      lim = 31'(RT_MAX[2]);
    end
    // fractional accumulator: 20 ns units outrun the 25 ns clock
    sum = tm_reg.acc + 12'(CLK_NS);
    if (clear)
      tm_next = '0;
    else if (run && !tm_reg.ovf)
    begin
      tm_next.acc = sum;
      if (sum >= {rns[10:0], 1'b0})
      begin
        tm_next.cnt = tm_reg.cnt + 31'h2;
        tm_next.acc = sum - {rns[10:0], 1'b0};
      end
      else if (sum >= rns)
      begin
        tm_next.cnt = tm_reg.cnt + 31'h1;
        tm_next.acc = sum - rns;
      end
      if (tm_next.cnt > lim)
      begin
        tm_next.ovf = 1'b1;
        tm_next.cnt = lim;
      end
    end
  end
  always_ff @(posedge clk)
    if (sys_rst)
      tm_reg <= '0;
    else
      tm_reg <= tm_next;
  assign count = tm_reg.cnt;
  assign ovf = tm_reg.ovf;
endmodule

// File: src/erc_prst_gen.sv
`timescale 1ns/1ps
module erc_prst_gen #(
  parameter erc_pkg::erc_tab_t PRST_CYC = erc_pkg::PRST_CYC_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic en,
  input wire logic [3:0] sel,
  // reset pulse, active high
  output logic pulse
);
  import erc_pkg::*;
  typedef struct packed {
    logic [31:0] cnt;
    logic [2:0] wcnt;
  } erc_pg_t;
  erc_pg_t pg_reg, pg_next;
  logic [3:0] idx;
  always_comb
  begin
    pg_next = pg_reg;
    // settings out of range fall back to the shortest interval
    idx = (sel >= 4'h1 && sel <= 4'hC) ? sel - 4'h1 : 4'h0;
    if (!en)
      pg_next = '0;
    else
    begin
      pg_next.cnt = pg_reg.cnt + 32'h1;
      if (pg_reg.wcnt != 3'h0)
        pg_next.wcnt = pg_reg.wcnt - 3'h1;
      if (pg_reg.cnt >= PRST_CYC[idx] - 1)
      begin
        pg_next.cnt = '0;
        pg_next.wcnt = 3'(PRST_W_CYC);
      end
    end
  end
  always_ff @(posedge clk)
    if (sys_rst)
      pg_reg <= '0;
    else
      pg_reg <= pg_next;
  assign pulse = pg_reg.wcnt != 3'h0;
endmodule

// File: src/erc_run_ctrl.sv
`timescale 1ns/1ps
module erc_run_ctrl #(
  parameter logic [15:0] BUS_TO_CYC = 16'(erc_pkg::BUS_TO_CYC),
  parameter erc_pkg::erc_tab_t PRST_CYC = erc_pkg::PRST_CYC_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // target bus and break sources
  input erc_pkg::erc_tgt_t tgt,
  input erc_pkg::erc_brk_t brk,
  // target control
  output logic target_reset_line_n,
  output logic halt_req,
  output logic stall,
  output logic trace_en,
  output logic running,
  // status report
  output erc_pkg::erc_rep_t rep
);
  import erc_pkg::*;
  typedef struct packed {
    erc_mode_t mode;
    logic [3:0] psel;
    logic [1:0] tres;
    logic [31:0] stop_addr;
    logic [7:0] asid;
    logic asid_en;
    logic stop_armed;
    logic [31:0] mon;
    logic [31:0] mon_cnt;
    logic running;
    logic conc;
    logic seq_seen;
    logic [CAUSE_W-1:0] cause;
    logic [15:0] idle_cnt;
    logic [31:0] last_addr;
    logic [31:0] last_pc;
    erc_rep_t rep;
    erc_stat_t prev_code;
    logic [31:0] prev_addr;
    logic [2:0] erst_cnt;
    logic rst_n;
    logic halt;
    logic stall;
    logic trace_en;
    logic clr_t;
    logic [31:0] rdata;
  } erc_st_t;
  erc_st_t st_reg, st_next;
  logic prst_pulse, t_ovf;
  logic [30:0] t_cnt;
  logic [CAUSE_W-1:0] vec;
  logic sw_ok, hw_ok, go, abort, conc_on, conc_off, stop_hit, tick;
  logic [3:0] ucode;
  erc_stat_t ccode;
  logic [31:0] caddr;

  erc_run_timer u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .clear(st_reg.clr_t),
    .run(st_reg.running),
    .res(st_reg.tres),
    .count(t_cnt),
    .ovf(t_ovf)
  );

  erc_prst_gen #(.PRST_CYC(PRST_CYC)) u_prst (
    .clk(clk),
    .sys_rst(sys_rst),
    .en(st_reg.running && st_reg.mode == MD_PERIODIC_RST),
    .sel(st_reg.psel),
    .pulse(prst_pulse)
  );

  ////////////////////////////////////////////////////////////////////////
  // break qualification
  always_comb
  begin
    go = wr && addr == OFF_CMD && wdata[CMD_GO];
    abort = wr && addr == OFF_CMD && wdata[CMD_ABORT];
    conc_on = wr && addr == OFF_CMD && wdata[CMD_CONC_ON];
    conc_off = wr && addr == OFF_CMD && wdata[CMD_CONC_OFF];
    // software points only in normal mode
    sw_ok = st_reg.mode == MD_NORMAL;
    hw_ok = st_reg.mode == MD_NORMAL || st_reg.mode == MD_TIMEOUT_BREAK;
    stop_hit = st_reg.stop_armed && tgt.fetch_valid
      && tgt.pc_fetch == st_reg.stop_addr
      && (!st_reg.asid_en || tgt.page_entry_high_reg == st_reg.asid)
      && st_reg.mode != MD_PERIODIC_RST;
    vec = '0;
    vec[CS_A +: 8] = hw_ok ? brk.ch_a : 8'h00;
    vec[CS_B +: 8] = hw_ok ? brk.ch_b : 8'h00;
    vec[CS_C +: 8] = hw_ok ? brk.ch_c : 8'h00;
    vec[CS_UBC] = hw_ok && brk.user_break_channel[0];
    // channel two dead while stop address armed
    vec[CS_UBC+1] = hw_ok && brk.user_break_channel[1]
      && !st_reg.stop_armed;
    vec[CS_UBC+2] = hw_ok && brk.user_break_channel[2];
    // channel one only after channel two
    vec[CS_SEQ] = st_reg.mode == MD_SEQ_BREAK && st_reg.seq_seen
      && brk.user_break_channel[0];
    vec[CS_KEY] = abort;
    vec[CS_BP] = sw_ok && brk.sw_bp;
    vec[CS_BSEQ] = sw_ok && brk.bp_seq;
    vec[CS_STOP] = stop_hit;
    // several hardware channels at once, pipeline skid
    vec[CS_MULTI] = $countones(vec[CS_SEQ-1:0]) > 1;
    vec[CS_TOVF] = st_reg.mode != MD_PERIODIC_RST && brk.trace_ovf;
    vec[CS_ILL] = tgt.brk_opcode;
    vec[CS_GUARD] = tgt.guard_viol;
    vec[CS_EMURST] = tgt.user_err;
    vec[CS_SUBTO] = st_reg.mode == MD_TIMEOUT_BREAK
      && brk.perf_timeout_counter;
    vec[CS_SUBCNT] = st_reg.mode == MD_TIMEOUT_BREAK && brk.perf_count_ovf;
  end

  ////////////////////////////////////////////////////////////////////////
  // execution status candidate
  always_comb
  begin
    ccode = ST_PC;
    caddr = st_reg.last_pc;
    if (!tgt.target_reset_line_n)
    begin
      ccode = ST_RESET;
      caddr = '0;
    end
    else if (!tgt.bus_request_line_n)
    begin
      ccode = ST_BUS_REQUEST;
      caddr = '0;
    end
    else if (!tgt.wait_n)
    begin
      ccode = ST_WAIT;
      caddr = tgt.refresh ? 32'h00000000 : tgt.addr;
    end
    else if (st_reg.idle_cnt >= BUS_TO_CYC)
    begin
      ccode = ST_BUS_TIMEOUT;
      caddr = st_reg.last_addr;
    end
    else if (tgt.sleep)
    begin
      ccode = ST_SLEEP;
      caddr = '0;
    end
    else if (tgt.standby)
    begin
      ccode = ST_STANDBY;
      caddr = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    st_next = st_reg;
    st_next.rep.valid = 1'b0;
    st_next.clr_t = 1'b0;
    tick = st_reg.mon_cnt + 32'h1 >= st_reg.mon;
    if (wr)
    begin
      case (addr)
        OFF_CTRL:
        begin
          st_next.mode = erc_mode_t'(wdata[2:0]);
          st_next.psel = wdata[PSEL_LSB +: 4];
          st_next.tres = wdata[TRES_LSB +: 2];
        end
        OFF_STOP:
        begin
          st_next.stop_addr = wdata;
          st_next.stop_armed = 1'b1;
        end
        OFF_ASID:
        begin
          st_next.asid = wdata[7:0];
          st_next.asid_en = wdata[ASID_EN_BIT];
        end
        OFF_MON:
          st_next.mon = wdata;
        default:
          st_next.mon = st_reg.mon;
      endcase
    end
    if (tgt.fetch_valid)
      st_next.last_pc = tgt.pc_fetch;
    if (tgt.bus_cycle)
    begin
      st_next.idle_cnt = '0;
      st_next.last_addr = tgt.addr;
    end
    else if (st_reg.idle_cnt < BUS_TO_CYC)
      st_next.idle_cnt = st_reg.idle_cnt + 16'h1;
    if (st_reg.erst_cnt != 3'h0)
      st_next.erst_cnt = st_reg.erst_cnt - 3'h1;
    if (go && !st_reg.running)
    begin
      st_next.running = 1'b1;
      st_next.cause = '0;
      st_next.seq_seen = 1'b0;
      st_next.clr_t = 1'b1;
      st_next.mon_cnt = '0;
      st_next.rep = '{1'b1, ST_RUNNING, 32'h00000000};
      st_next.prev_code = ST_RUNNING;
      st_next.prev_addr = '0;
    end
    else if (st_reg.running)
    begin
      if (st_reg.mode == MD_SEQ_BREAK && brk.user_break_channel[1]
          && !st_reg.stop_armed)
        st_next.seq_seen = 1'b1;
      // no concurrent access in periodic reset
      if (conc_on && st_reg.mode != MD_PERIODIC_RST)
        st_next.conc = 1'b1;
      if (conc_off && st_reg.conc)
      begin
        st_next.conc = 1'b0;
        st_next.rep = '{1'b1, ST_RUNNING, 32'h00000000};
        st_next.prev_code = ST_RUNNING;
        st_next.prev_addr = '0;
      end
      else
      begin
        st_next.mon_cnt = tick ? 32'h0 : st_reg.mon_cnt + 32'h1;
        // sample at interval, report on change
        if (tick && (ccode != st_reg.prev_code
            || caddr != st_reg.prev_addr))
        begin
          st_next.rep = '{1'b1, ccode, caddr};
          st_next.prev_code = ccode;
          st_next.prev_addr = caddr;
        end
      end
      if (|vec)
      begin
        st_next.running = 1'b0;
        st_next.conc = 1'b0;
        st_next.cause = st_reg.cause | vec;
        st_next.stop_armed = 1'b0;
      end
      if (tgt.user_err)
        st_next.erst_cnt = 3'(PRST_W_CYC);
    end
    st_next.rst_n = !(prst_pulse || st_next.erst_cnt != 3'h0);
    st_next.halt = !st_next.running;
    // stall target while emulator touches memory
    st_next.stall = st_next.conc && brk.mem_access;
    st_next.trace_en = st_next.running
      && st_next.mode != MD_PERIODIC_RST;
    st_next.rdata = '0;
    if (rd)
    begin
      ucode = 4'(st_reg.rep.code);
      case (addr)
        OFF_CTRL:
          st_next.rdata = {22'h0, st_reg.tres, st_reg.psel, 1'b0,
            st_reg.mode};
        OFF_STOP:
          st_next.rdata = st_reg.stop_addr;
        OFF_ASID:
          st_next.rdata = {23'h0, st_reg.asid_en, st_reg.asid};
        OFF_STAT:
          st_next.rdata = {24'h0, ucode, st_reg.stop_armed,
            st_reg.stall, st_reg.conc, st_reg.running};
        OFF_CAUSE_LO:
          st_next.rdata = st_reg.cause[31:0];
        OFF_CAUSE_HI:
          st_next.rdata = {25'h0, st_reg.cause[CAUSE_W-1:32]};
        OFF_RTIME:
          st_next.rdata = {t_ovf, t_cnt};
        OFF_REP:
          st_next.rdata = st_reg.rep.addr;
        OFF_MON:
          st_next.rdata = st_reg.mon;
        default:
          st_next.rdata = '0;
      endcase
    end
    else
      ucode = 4'h0;
  end

  always_ff @(posedge clk)
    if (sys_rst)
    begin
      st_reg <= '0;
      st_reg.mon <= MON_RST;
      st_reg.rst_n <= 1'b1;
      st_reg.halt <= 1'b1;
    end
    else
      st_reg <= st_next;

  assign rdata = st_reg.rdata;
  assign target_reset_line_n = st_reg.rst_n;
  assign halt_req = st_reg.halt;
  assign stall = st_reg.stall;
  assign trace_en = st_reg.trace_en;
  assign running = st_reg.running;
  assign rep = st_reg.rep;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // abort stays live in periodic reset, so key bit is left out
  property p_prst_mask;
    st_reg.running && st_reg.mode == MD_PERIODIC_RST
      |=> {st_reg.cause[CS_BSEQ:CS_BP], st_reg.cause[CS_SEQ:0],
        st_reg.cause[CS_TOVF]} == $past({st_reg.cause[CS_BSEQ:CS_BP],
        st_reg.cause[CS_SEQ:0], st_reg.cause[CS_TOVF]});
  endproperty
  a_prst_mask: assert property (p_prst_mask)
    else $error("break taken in periodic reset");

  property p_prst_conc;
    st_reg.mode == MD_PERIODIC_RST && !st_reg.conc |=> !st_reg.conc;
  endproperty
  a_prst_conc: assert property (p_prst_conc)
    else $error("concurrent access in periodic reset");

  property p_nobrk;
    st_reg.running && st_reg.mode == MD_NO_BREAK
      |=> !$rose(st_reg.cause[CS_BP]) && st_reg.cause[CS_UBC+2:0] == '0;
  endproperty
  a_nobrk: assert property (p_nobrk)
    else $error("break taken while breaks disabled");

  property p_seq;
    $rose(st_reg.cause[CS_SEQ]) |-> $past(st_reg.seq_seen)
      && $past(st_reg.mode) == MD_SEQ_BREAK;
  endproperty
  a_seq: assert property (p_seq)
    else $error("sequence stop without channel two first");

  property p_stop;
    st_reg.running && stop_hit
      |=> !st_reg.running && st_reg.cause[CS_STOP] && !st_reg.stop_armed
      ##1 halt_req;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop address did not halt");

  property p_ubc2;
    st_reg.running && st_reg.stop_armed
      |=> !$rose(st_reg.cause[CS_UBC+1]);
  endproperty
  a_ubc2: assert property (p_ubc2)
    else $error("channel two fired with stop armed");

  property p_asid;
    st_reg.running && st_reg.asid_en
      && tgt.page_entry_high_reg != st_reg.asid
      |=> !$rose(st_reg.cause[CS_STOP]);
  endproperty
  a_asid: assert property (p_asid)
    else $error("stop fired with identifier mismatch");

  property p_stall;
    st_reg.conc && brk.mem_access && !conc_off && vec == '0
      |=> stall;
  endproperty
  a_stall: assert property (p_stall)
    else $error("no stall on emulator access");

  property p_run_rep;
    go && !st_reg.running
      |=> rep.valid && rep.code == ST_RUNNING ##1 !rep.valid;
  endproperty
  a_run_rep: assert property (p_run_rep)
    else $error("running not reported once");

  property p_erst;
    st_reg.running && tgt.user_err
      |=> st_reg.cause[CS_EMURST] ##1 !target_reset_line_n [*3];
  endproperty
  a_erst: assert property (p_erst)
    else $error("user error without target reset");

  c_stop: cover property (st_reg.running && stop_hit);
  c_seq: cover property ($rose(st_reg.cause[CS_SEQ]));
  c_conc: cover property (st_reg.conc && conc_off);
  c_bus_timeout_status: cover property (rep.valid && rep.code == ST_BUS_TIMEOUT);
endmodule

// File: testbench/erc_tgt_model.sv
`timescale 1ns/1ps
module erc_tgt_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // emulator control
  input wire logic halt_req,
  input wire logic rst_drive_n,
  input wire logic [31:0] start_pc,
  // pin levels set by the bench
  input erc_pkg::erc_tgt_t base,
  // target bus
  output erc_pkg::erc_tgt_t tgt
);
  import erc_pkg::*;
  logic [31:0] pc_reg;
  ////////////////////////////////////////////////////////////////////////
  // pc reloads start_pc while halted so the first fetch after go is start_pc
  always_ff @(posedge clk)
  begin
    if (sys_rst || halt_req)
      pc_reg <= start_pc;
    else
      pc_reg <= pc_reg + 32'h00000002;
  end
  always_comb
  begin
    tgt = base;
    tgt.fetch_valid = !halt_req;
    // halted core shows no stale fetch address
    tgt.pc_fetch = halt_req ? ~pc_reg : pc_reg;
    tgt.bus_cycle = !halt_req;
    tgt.target_reset_line_n = rst_drive_n & base.target_reset_line_n;
  end
endmodule

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import erc_pkg::*;
  localparam erc_tab_t PCYC = '{default: 20};
  localparam logic [31:0] PC0 = 32'h00001000;
  logic clk;
  logic sys_rst;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  erc_tgt_t base;
  erc_tgt_t tgt;
  erc_brk_t brk;
  logic target_reset_line_n;
  logic halt_req;
  logic stall;
  logic trace_en;
  logic running;
  erc_rep_t rep;
  erc_stat_t last_code;
  logic [31:0] rv;
  int n_fail;
  int compares;
  int n_rep;
  int n_low;
  int n0;
  ////////////////////////////////////////////////////////////////////////
  erc_run_ctrl #(.BUS_TO_CYC(16'h0040), .PRST_CYC(PCYC)) erc_run_ctrl_inst (
    .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .tgt(tgt), .brk(brk),
    .target_reset_line_n(target_reset_line_n), .halt_req(halt_req),
    .stall(stall), .trace_en(trace_en), .running(running), .rep(rep));
  erc_tgt_model erc_tgt_model_inst (
    .clk(clk), .sys_rst(sys_rst), .halt_req(halt_req),
    .rst_drive_n(target_reset_line_n), .start_pc(PC0), .base(base),
    .tgt(tgt));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // report pulses last one cycle, so catch every one
  always @(posedge clk)
  begin
    if (rep.valid === 1'b1)
    begin
      last_code <= rep.code;
      n_rep <= n_rep + 1;
    end
    if (target_reset_line_n === 1'b0)
      n_low <= n_low + 1;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic probe(input logic v, input logic e);
    #1;
    chk(32'(v), 32'(e));
    @(posedge clk);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic go(input erc_mode_t m, input logic [3:0] s);
    wr_reg(OFF_CTRL, 32'(m) | (32'(s) << PSEL_LSB));
    wr_reg(OFF_CMD, 32'h00000001 << CMD_GO);
    cyc(2);
  endtask
  task automatic wait_stop(input logic [31:0] m, input logic [31:0] lo,
    input logic [31:0] hi);
    int i;
    for (i = 0; i < 300 && running !== 1'b0; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (i == 300)
    begin
      n_fail++;
      wrap_up();
    end
    rd_reg(OFF_CAUSE_LO, rv);
    chk(rv & m, lo);
    rd_reg(OFF_CAUSE_HI, rv);
    chk(rv, hi);
  endtask
  task automatic pulse_brk(input erc_brk_t b);
    @(posedge clk);
    brk <= b;
    @(posedge clk);
    brk <= '0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    rd_reg(OFF_STAT, rv);
    chk(rv, 32'h00000000);
    rd_reg(OFF_MON, rv);
    chk(rv, MON_RST);
    wr_reg(8'h30, 32'hFFFFFFFF);
    rd_reg(8'h30, rv);
    chk(rv, 32'h00000000);
  endtask
  task automatic s_stop();
    wr_reg(OFF_STOP, PC0 + 32'h00000008);
    brk.user_break_channel <= 3'b010;
    go(MD_NORMAL, 4'h0);
    chk(32'(last_code), 32'(ST_RUNNING));
    wait_stop('1, 32'h1 << CS_STOP, 32'h0);
    // second run: stop address gone, channel two live again
    go(MD_NORMAL, 4'h0);
    wait_stop('1, 32'h1 << (CS_UBC + 1), 32'h0);
    brk <= '0;
  endtask
  task automatic s_multi();
    erc_brk_t b;
    b = '0;
    b.ch_a = 8'h01;
    b.ch_b = 8'h02;
    go(MD_NORMAL, 4'h0);
    pulse_brk(b);
    wait_stop('1, 32'h00000201, 32'h1);
  endtask
  task automatic s_periodic();
    brk.ch_a <= 8'hFF;
    brk.sw_bp <= 1'b1;
    brk.user_break_channel <= 3'b111;
    n_low = 0;
    go(MD_PERIODIC_RST, 4'h1);
    wr_reg(OFF_CMD, 32'h00000001 << CMD_CONC_ON);
    cyc(60);
    probe(running, 1'b1);
    probe(trace_en, 1'b0);
    rd_reg(OFF_STAT, rv);
    chk(rv & 32'h00000002, 32'h0);
    chk(32'(n_low >= 8), 32'h1);
    wr_reg(OFF_CMD, 32'h00000001 << CMD_ABORT);
    wait_stop('1, 32'h1 << CS_KEY, 32'h0);
  endtask
  task automatic s_nobrk();
    go(MD_NO_BREAK, 4'h0);
    cyc(20);
    probe(running, 1'b1);
    base.brk_opcode <= 1'b1;
    @(posedge clk);
    base.brk_opcode <= 1'b0;
    wait_stop('1, 32'h0, 32'h1 << (CS_ILL - 32));
    brk <= '0;
  endtask
  task automatic s_tmo();
    erc_brk_t b;
    for (int i = 0; i < 2; i++)
    begin
      b = '0;
      b.perf_timeout_counter = (i == 0);
      b.perf_count_ovf = (i == 1);
      brk.sw_bp <= 1'b1;
      go(MD_TIMEOUT_BREAK, 4'h0);
      cyc(10);
      probe(running, 1'b1);
      pulse_brk(b);
      wait_stop('1, 32'h0, 32'h1 << (CS_SUBTO - 32 + i));
    end
  endtask
  task automatic s_seq();
    erc_brk_t b;
    b = '0;
    b.sw_bp = 1'b1;
    go(MD_SEQ_BREAK, 4'h0);
    b.user_break_channel = 3'b001;
    pulse_brk(b);
    cyc(10);
    probe(running, 1'b1);
    b.user_break_channel = 3'b010;
    pulse_brk(b);
    b.user_break_channel = 3'b001;
    pulse_brk(b);
    wait_stop(32'h1 << CS_SEQ | 32'h1 << CS_BP, 32'h1 << CS_SEQ, 32'h0);
  endtask
  task automatic s_err();
    go(MD_NORMAL, 4'h0);
    n_low = 0;
    base.user_err <= 1'b1;
    @(posedge clk);
    base.user_err <= 1'b0;
    wait_stop('1, 32'h0, 32'h1 << (CS_EMURST - 32));
    cyc(8);
    chk(32'(n_low), 32'd4);
  endtask
  task automatic s_rep();
    wr_reg(OFF_MON, 32'h00000010);
    base.wait_n <= 1'b0;
    base.addr <= 32'h00001234;
    n0 = n_rep;
    go(MD_NORMAL, 4'h0);
    cyc(60);
    chk(32'(last_code), 32'(ST_WAIT));
    chk(32'(n_rep - n0), 32'd2);
    rd_reg(OFF_REP, rv);
    chk(rv, 32'h00001234);
    base.bus_request_line_n <= 1'b0;
    cyc(40);
    chk(32'(last_code), 32'(ST_BUS_REQUEST));
    wr_reg(OFF_CMD, 32'h00000001 << CMD_CONC_ON);
    brk.mem_access <= 1'b1;
    cyc(2);
    probe(stall, 1'b1);
    brk.mem_access <= 1'b0;
    wr_reg(OFF_CMD, 32'h00000001 << CMD_CONC_OFF);
    #1;
    chk(32'(rep.code), 32'(ST_RUNNING));
    wr_reg(OFF_CMD, 32'h00000001 << CMD_ABORT);
    wait_stop('1, 32'h1 << CS_KEY, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    brk = '0;
    base = '0;
    base.wait_n = 1'b1;
    base.bus_request_line_n = 1'b1;
    base.target_reset_line_n = 1'b1;
    n_fail = 0;
    compares = 0;
    n_rep = 0;
    n_low = 0;
    last_code = ST_NONE;
    cyc(10);
    sys_rst <= 1'b0;
    s_reset();
    s_stop();
    s_multi();
    s_periodic();
    s_nobrk();
    s_tmo();
    s_seq();
    s_err();
    s_rep();
    wrap_up();
  end
endmodule
